// ### src/thermo_channel_consts.svh
// constants for the thermoelectric channel set point and status block
`ifndef THERMO_CHANNEL_CONSTS_SVH
`define THERMO_CHANNEL_CONSTS_SVH

// channel count and widths
`define NUM_CH 4
`define CH_W 2
`define ADDR_W 8
`define DATA_W 32
`define SP_W 24
`define STEP_W 14
`define EV_W 16
`define STB_W 8
`define SENS_W 3
`define POS_W 3
`define MODE_W 2

// step size limits and reset value
`define STEP_MIN 14'h0001
`define STEP_MAX 14'h270F
`define STEP_RST 14'h0001

// sensor codes returned by the sensor query
`define SENS_NONE 3'h0
`define SENS_THERM_HI 3'h1
`define SENS_THERM_LO 3'h2
`define SENS_LIN_V 3'h3
`define SENS_CURR 3'h4
`define SENS_RTD 3'h5

// selector switch positions
`define POS_THERM 3'h0
`define POS_LIN_V 3'h1
`define POS_CURR 3'h2
`define POS_RTD 3'h3

// register byte offsets
`define REG_CHAN_SEL 8'h00
`define REG_MODE 8'h04
`define REG_SET_ITE 8'h08
`define REG_SET_R 8'h0C
`define REG_SET_T 8'h10
`define REG_STEP 8'h14
`define REG_STEP_CMD 8'h18
`define REG_SENSOR 8'h1C
`define REG_CHAN_SUM 8'h20
`define REG_EVENT 8'h24
`define REG_EVENT_EN 8'h28
`define REG_COND_EN 8'h2C
`define REG_MEAS_T 8'h30
`define REG_STATUS_BYTE 8'h34
`define REG_CHAN_EN 8'h38
`define REG_IRQ_STATUS 8'h3C
`define REG_IRQ_MASK 8'h40

// field positions
`define EV_SENSOR_BIT 8
`define SUM_EVENT_BIT 0
`define SUM_COND_BIT 1
`define STB_EVENT_BIT 0
`define STB_COND_BIT 1
`define CMD_INC_BIT 0
`define CMD_DEC_BIT 1
`define IRQ_SENSOR_BIT 0
`define IRQ_STEP_REJ_BIT 1
`define IRQ_REFRESH_BIT 2
`define IRQ_W 3

// reset values
`define CHAN_EN_RST 4'hF
`define EN_RST 16'h0000
`define IRQ_MASK_RST 3'h0

// measurement refresh timing
`define REFRESH_MS 600
`define CLK_KHZ 250000
`define REFRESH_CYCLES (`REFRESH_MS * `CLK_KHZ)
`define REFRESH_CNT_W 28

`endif

// ### src/thermo_pkg.sv
// types shared by the thermoelectric channel block
package thermo_pkg;
`include "thermo_channel_consts.svh"

    // control modes of a channel
    typedef enum logic [`MODE_W-1:0] {
        MODE_ITE,
        MODE_R,
        MODE_T
    } mode_t;

    // rear selector switches of one channel
    typedef struct packed {
        logic [`POS_W-1:0] position;
        logic thermistor_current_switch;
    } sensor_sw_t;

    // drive request towards the analog loop of one channel
    typedef struct packed {
        mode_t mode;
        logic signed [`SP_W-1:0] target;
    } ctrl_out_t;
endpackage

// ### src/refresh_divider.sv
// divider giving a one-cycle measurement refresh pulse
`timescale 1ns/1ps
`include "thermo_channel_consts.svh"
module refresh_divider #(
    parameter int unsigned PERIOD = `REFRESH_CYCLES
) (
    input wire logic clock,
    input wire logic sys_rst,
    output logic tick
);
    localparam logic [`REFRESH_CNT_W-1:0] LAST = `REFRESH_CNT_W'(PERIOD - 1);

    logic [`REFRESH_CNT_W-1:0] count_ff;
    logic tick_ff;

    // free running count, wraps at the period
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            count_ff <= '0;
        end else if (count_ff == LAST) begin
            count_ff <= '0;
        end else begin
            count_ff <= count_ff + `REFRESH_CNT_W'(1);
        end
    end

    // registered pulse so the consumer sees a clean edge
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= (count_ff == LAST);
        end
    end

    assign tick = tick_ff;
endmodule

// ### src/thermo_channel_setpoint_status.sv
// per-channel set point, step, sensor and status command logic
// Behaviour
// - sensor codes 1..5 from switch setting
// - invalid switch setting reads code zero
// - switch change sets event bit 8, display
// - sensor selection has no remote write
// - set point reads return stored values
// - drive only active mode's set point
// - channel summary: event 1 plus condition 2
// - enabled channels OR into status bits 0,1
// - step accepted only from 1 to 9999
// - inc/dec moves active mode set point
// - step unit is active mode's resolution
// - step read returns stored integer step
// - temperature write stores T set point
// - measured temperature refreshed every 600 ms
// - measured temperature valid in all modes
// - measurement carries six significant digits
`timescale 1ns/1ps
`include "thermo_channel_consts.svh"
module thermo_channel_setpoint_status
    import thermo_pkg::*;
#(
    parameter int unsigned REFRESH_CYCLES = `REFRESH_CYCLES
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [`ADDR_W-1:0] addr,
    input wire logic [`DATA_W-1:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [`DATA_W-1:0] rdata,
    input wire sensor_sw_t sensor_sw [`NUM_CH],
    input wire logic [`EV_W-1:0] cond_in [`NUM_CH],
    input wire logic signed [`SP_W-1:0] meas_temp_in [`NUM_CH],
    output ctrl_out_t ctrl_out [`NUM_CH],
    output logic [`SENS_W-1:0] display_code [`NUM_CH],
    output logic [`STB_W-1:0] status_byte,
    output logic irq
);
    // switch setting to sensor code
    function automatic logic [`SENS_W-1:0] sensor_decode(input sensor_sw_t sw);
        logic [`SENS_W-1:0] code;
        code = `SENS_NONE;
        case (sw.position)
            `POS_THERM: code = sw.thermistor_current_switch ? `SENS_THERM_HI : `SENS_THERM_LO;
            `POS_LIN_V: code = `SENS_LIN_V;
            `POS_CURR: code = `SENS_CURR;
            `POS_RTD: code = `SENS_RTD;
            default: code = `SENS_NONE;
        endcase
        return code;
    endfunction

    // signed set point or measurement, sign-extended to a bus word
    function automatic logic [`DATA_W-1:0] sext(input logic signed [`SP_W-1:0] v);
        return {{(`DATA_W-`SP_W){v[`SP_W-1]}}, v};
    endfunction

    // register hit on a write strobe
    function automatic logic wr_hit(input logic [`ADDR_W-1:0] a, input logic [`ADDR_W-1:0] off, input logic s);
        return s && (a == off);
    endfunction

    logic [`CH_W-1:0] sel_ff;
    mode_t mode_ff [`NUM_CH];
    logic signed [`SP_W-1:0] set_ite_ff [`NUM_CH];
    logic signed [`SP_W-1:0] set_r_ff [`NUM_CH];
    logic signed [`SP_W-1:0] set_t_ff [`NUM_CH];
    logic [`STEP_W-1:0] step_ff [`NUM_CH];
    logic [`EV_W-1:0] event_ff [`NUM_CH];
    logic [`EV_W-1:0] event_en_ff [`NUM_CH];
    logic [`EV_W-1:0] cond_en_ff [`NUM_CH];
    logic signed [`SP_W-1:0] meas_ff [`NUM_CH];
    sensor_sw_t prev_sw_ff [`NUM_CH];
    logic primed_ff;
    logic [`SENS_W-1:0] disp_ff [`NUM_CH];
    ctrl_out_t ctrl_ff [`NUM_CH];
    logic [`NUM_CH-1:0] chan_en_ff;
    logic [`STB_W-1:0] stb_ff;
    logic [`IRQ_W-1:0] irq_status_ff;
    logic [`IRQ_W-1:0] irq_mask_ff;
    logic [`DATA_W-1:0] rdata_ff;
    logic [`DATA_W-1:0] nxt_rdata;
    logic [`IRQ_W-1:0] nxt_irq_status;

    logic refresh_tick;
    logic step_cmd;
    logic inc_cmd;
    logic dec_cmd;
    logic step_wr;
    logic step_ok;
    logic step_rej;
    logic signed [`SP_W-1:0] step_delta;
    logic [`NUM_CH-1:0] sw_change;
    logic [`NUM_CH-1:0] ev_sum;
    logic [`NUM_CH-1:0] cond_sum;

    refresh_divider #(
        .PERIOD(REFRESH_CYCLES)
    ) u_refresh (
        .clock(clock),
        .sys_rst(sys_rst),
        .tick(refresh_tick)
    );

    // command decode; increment wins if both bits are written at once
    assign step_cmd = wr_hit(addr, `REG_STEP_CMD, wr_en);
    assign inc_cmd = step_cmd && wdata[`CMD_INC_BIT];
    assign dec_cmd = step_cmd && wdata[`CMD_DEC_BIT] && !wdata[`CMD_INC_BIT];
    assign step_wr = wr_hit(addr, `REG_STEP, wr_en);
    assign step_ok = (wdata[`DATA_W-1:`STEP_W] == '0) && (wdata[`STEP_W-1:0] >= `STEP_MIN)
        && (wdata[`STEP_W-1:0] <= `STEP_MAX);
    assign step_rej = step_wr && !step_ok;
    // step units equal the stored set point resolution, so no scaling is needed
    assign step_delta = inc_cmd ? `SP_W'(step_ff[sel_ff]) : -`SP_W'(step_ff[sel_ff]);

    // channel select; all but the channel enable, status byte and interrupt registers address this channel
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sel_ff <= '0;
        end else if (wr_hit(addr, `REG_CHAN_SEL, wr_en)) begin
            sel_ff <= wdata[`CH_W-1:0];
        end
    end

    // mode per channel; the unused encoding is ignored
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            for (int i = 0; i < `NUM_CH; i++) begin
                mode_ff[i] <= MODE_T;
            end
        end else if (wr_hit(addr, `REG_MODE, wr_en) && (wdata[`MODE_W-1:0] <= MODE_T)) begin
            mode_ff[sel_ff] <= mode_t'(wdata[`MODE_W-1:0]);
        end
    end

    // set points: direct writes, or step on the active mode only
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            for (int i = 0; i < `NUM_CH; i++) begin
                set_ite_ff[i] <= '0;
                set_r_ff[i] <= '0;
                set_t_ff[i] <= '0;
            end
        end else begin
            if (wr_hit(addr, `REG_SET_ITE, wr_en)) begin
                set_ite_ff[sel_ff] <= wdata[`SP_W-1:0];
            end
            if (wr_hit(addr, `REG_SET_R, wr_en)) begin
                set_r_ff[sel_ff] <= wdata[`SP_W-1:0];
            end
            if (wr_hit(addr, `REG_SET_T, wr_en)) begin
                set_t_ff[sel_ff] <= wdata[`SP_W-1:0];
            end
            if (inc_cmd || dec_cmd) begin
                case (mode_ff[sel_ff])
                    MODE_ITE: set_ite_ff[sel_ff] <= set_ite_ff[sel_ff] + step_delta;
                    MODE_R: set_r_ff[sel_ff] <= set_r_ff[sel_ff] + step_delta;
                    MODE_T: set_t_ff[sel_ff] <= set_t_ff[sel_ff] + step_delta;
                    default: set_t_ff[sel_ff] <= set_t_ff[sel_ff];
                endcase
            end
        end
    end

    // step size; out of range values leave the old step in place
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            for (int i = 0; i < `NUM_CH; i++) begin
                step_ff[i] <= `STEP_RST;
            end
        end else if (step_wr && step_ok) begin
            step_ff[sel_ff] <= wdata[`STEP_W-1:0];
        end
    end

    // switch change detection; first sample after reset only primes
    always_comb begin
        for (int i = 0; i < `NUM_CH; i++) begin
            sw_change[i] = primed_ff && (sensor_sw[i] != prev_sw_ff[i]);
        end
    end

    // sensor switches are only sampled, software has no path to them
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            primed_ff <= 1'b0;
            for (int i = 0; i < `NUM_CH; i++) begin
                prev_sw_ff[i] <= '0;
                disp_ff[i] <= `SENS_NONE;
            end
        end else begin
            primed_ff <= 1'b1;
            for (int i = 0; i < `NUM_CH; i++) begin
                prev_sw_ff[i] <= sensor_sw[i];
                if (sw_change[i] || !primed_ff) begin
                    disp_ff[i] <= sensor_decode(sensor_sw[i]);
                end
            end
        end
    end

    // event registers: write one to clear, a new event wins over the clear
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            for (int i = 0; i < `NUM_CH; i++) begin
                event_ff[i] <= '0;
            end
        end else begin
            for (int i = 0; i < `NUM_CH; i++) begin
                logic [`EV_W-1:0] clr;
                logic [`EV_W-1:0] set;
                clr = '0;
                set = '0;
                if (wr_hit(addr, `REG_EVENT, wr_en) && (sel_ff == `CH_W'(i))) begin
                    clr = wdata[`EV_W-1:0];
                end
                set[`EV_SENSOR_BIT] = sw_change[i];
                event_ff[i] <= (event_ff[i] & ~clr) | set;
            end
        end
    end

    // summary enables and channel enables
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            chan_en_ff <= `CHAN_EN_RST;
            for (int i = 0; i < `NUM_CH; i++) begin
                event_en_ff[i] <= `EN_RST;
                cond_en_ff[i] <= `EN_RST;
            end
        end else begin
            if (wr_hit(addr, `REG_CHAN_EN, wr_en)) begin
                chan_en_ff <= wdata[`NUM_CH-1:0];
            end
            if (wr_hit(addr, `REG_EVENT_EN, wr_en)) begin
                event_en_ff[sel_ff] <= wdata[`EV_W-1:0];
            end
            if (wr_hit(addr, `REG_COND_EN, wr_en)) begin
                cond_en_ff[sel_ff] <= wdata[`EV_W-1:0];
            end
        end
    end

    // per channel summaries of enabled events and conditions
    always_comb begin
        for (int i = 0; i < `NUM_CH; i++) begin
            ev_sum[i] = |(event_ff[i] & event_en_ff[i]);
            cond_sum[i] = |(cond_in[i] & cond_en_ff[i]);
        end
    end

    // status byte: any enabled channel can raise either bit
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            stb_ff <= '0;
        end else begin
            stb_ff <= '0;
            stb_ff[`STB_EVENT_BIT] <= |(ev_sum & chan_en_ff);
            stb_ff[`STB_COND_BIT] <= |(cond_sum & chan_en_ff);
        end
    end

    // measurement latch; runs regardless of mode
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            for (int i = 0; i < `NUM_CH; i++) begin
                meas_ff[i] <= '0;
            end
        end else if (refresh_tick) begin
            for (int i = 0; i < `NUM_CH; i++) begin
                meas_ff[i] <= meas_temp_in[i];
            end
        end
    end

    // drive target follows the active mode; other set points stay idle
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            for (int i = 0; i < `NUM_CH; i++) begin
                ctrl_ff[i] <= '{mode: MODE_T, target: '0};
            end
        end else begin
            for (int i = 0; i < `NUM_CH; i++) begin
                ctrl_ff[i].mode <= mode_ff[i];
                case (mode_ff[i])
                    MODE_ITE: ctrl_ff[i].target <= set_ite_ff[i];
                    MODE_R: ctrl_ff[i].target <= set_r_ff[i];
                    MODE_T: ctrl_ff[i].target <= set_t_ff[i];
                    default: ctrl_ff[i].target <= '0;
                endcase
            end
        end
    end

    // interrupt status, sticky; a new event wins over a write-one clear
    always_comb begin
        nxt_irq_status = irq_status_ff;
        if (wr_hit(addr, `REG_IRQ_STATUS, wr_en)) begin
            nxt_irq_status = irq_status_ff & ~wdata[`IRQ_W-1:0];
        end
        if (|sw_change) begin
            nxt_irq_status[`IRQ_SENSOR_BIT] = 1'b1;
        end
        if (step_rej) begin
            nxt_irq_status[`IRQ_STEP_REJ_BIT] = 1'b1;
        end
        if (refresh_tick) begin
            nxt_irq_status[`IRQ_REFRESH_BIT] = 1'b1;
        end
    end

    // interrupt status and mask registers
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            irq_status_ff <= '0;
            irq_mask_ff <= `IRQ_MASK_RST;
        end else begin
            irq_status_ff <= nxt_irq_status;
            if (wr_hit(addr, `REG_IRQ_MASK, wr_en)) begin
                irq_mask_ff <= wdata[`IRQ_W-1:0];
            end
        end
    end

    // read mux; unmapped offsets read zero
    always_comb begin
        nxt_rdata = '0;
        case (addr)
            `REG_CHAN_SEL: nxt_rdata[`CH_W-1:0] = sel_ff;
            `REG_MODE: nxt_rdata[`MODE_W-1:0] = mode_ff[sel_ff];
            `REG_SET_ITE: nxt_rdata = sext(set_ite_ff[sel_ff]);
            `REG_SET_R: nxt_rdata = sext(set_r_ff[sel_ff]);
            `REG_SET_T: nxt_rdata = sext(set_t_ff[sel_ff]);
            `REG_STEP: nxt_rdata[`STEP_W-1:0] = step_ff[sel_ff];
            `REG_SENSOR: nxt_rdata[`SENS_W-1:0] = sensor_decode(sensor_sw[sel_ff]);
            `REG_CHAN_SUM: begin
                nxt_rdata[`SUM_EVENT_BIT] = ev_sum[sel_ff];
                nxt_rdata[`SUM_COND_BIT] = cond_sum[sel_ff];
            end
            `REG_EVENT: nxt_rdata[`EV_W-1:0] = event_ff[sel_ff];
            `REG_EVENT_EN: nxt_rdata[`EV_W-1:0] = event_en_ff[sel_ff];
            `REG_COND_EN: nxt_rdata[`EV_W-1:0] = cond_en_ff[sel_ff];
            // fixed point in 0.0001 degC keeps six significant digits
            `REG_MEAS_T: nxt_rdata = sext(meas_ff[sel_ff]);
            `REG_STATUS_BYTE: nxt_rdata[`STB_W-1:0] = stb_ff;
            `REG_CHAN_EN: nxt_rdata[`NUM_CH-1:0] = chan_en_ff;
            `REG_IRQ_STATUS: nxt_rdata[`IRQ_W-1:0] = irq_status_ff;
            `REG_IRQ_MASK: nxt_rdata[`IRQ_W-1:0] = irq_mask_ff;
            default: nxt_rdata = '0;
        endcase
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rdata_ff <= '0;
        end else begin
            rdata_ff <= rd_en ? nxt_rdata : '0;
        end
    end

    assign rdata = rdata_ff;
    assign status_byte = stb_ff;
    assign irq = |(irq_status_ff & irq_mask_ff);
    assign ctrl_out = ctrl_ff;
    assign display_code = disp_ff;
endmodule

// ### verif/thermo_monitor.sv
// port checker for the thermo channel set point and status block
`timescale 1ns/1ps
`include "thermo_channel_consts.svh"
module thermo_monitor
    import thermo_pkg::*;
#(
    parameter int unsigned REFRESH_CYCLES = 20
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [`ADDR_W-1:0] addr,
    input wire logic [`DATA_W-1:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [`DATA_W-1:0] rdata,
    input wire sensor_sw_t sensor_sw [`NUM_CH],
    input wire logic [`EV_W-1:0] cond_in [`NUM_CH],
    input wire logic signed [`SP_W-1:0] meas_temp_in [`NUM_CH],
    input wire ctrl_out_t ctrl_out [`NUM_CH],
    input wire logic [`SENS_W-1:0] display_code [`NUM_CH],
    input wire logic [`STB_W-1:0] status_byte,
    input wire logic irq
);
    logic [`CH_W-1:0] sel_ff;
    logic [`SENS_W-1:0] sel_code;

    // expected code from the rear switches; unknown positions give zero
    function automatic logic [`SENS_W-1:0] code_of(sensor_sw_t s);
        if (s.position == 3'h0) return s.thermistor_current_switch ? 3'h1 : 3'h2;
        if (s.position < 3'h4) return s.position + 3'h2;
        return 3'h0;
    endfunction

    // own copy of the channel select, so reads can be judged per channel
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sel_ff <= '0;
        end else if (wr_en && addr == `REG_CHAN_SEL) begin
            sel_ff <= wdata[`CH_W-1:0];
        end
    end
    assign sel_code = code_of(sensor_sw[sel_ff]);

    default clocking mon_cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    sequence read_of(logic [`ADDR_W-1:0] a);
        rd_en && addr == a;
    endsequence
    // a drive change needs a bus write one or two edges earlier, or a reset just before
    sequence recent_write;
        $past(wr_en) || $past(wr_en, 2) || $past(sys_rst);
    endsequence

    sensor_read_a: assert property (read_of(`REG_SENSOR) |=> rdata == 32'($past(sel_code)))
        else $error("sensor read code wrong");
    step_range_a: assert property (read_of(`REG_STEP) |=> rdata >= 32'h1 && rdata <= 32'h270F)
        else $error("step read outside accepted range");
    chan_sum_a: assert property (read_of(`REG_CHAN_SUM) |=> rdata[31:2] == '0)
        else $error("channel summary has stray bits");
    read_idle_a: assert property (!rd_en |=> rdata == '0)
        else $error("read data outside its cycle");
    status_bits_a: assert property (status_byte[7:2] == '0)
        else $error("status byte upper bits set");
    mode_legal_a: assert property (ctrl_out[0].mode != 2'h3)
        else $error("drive mode illegal");
    target_hold_a: assert property ($changed(ctrl_out[0]) |-> recent_write)
        else $error("drive changed with no write");
    for (genvar i = 0; i < `NUM_CH; i++) begin : g_disp
        display_code_a: assert property (!$past(sys_rst) |-> display_code[i] == code_of($past(sensor_sw[i])))
            else $error("display code does not follow switches");
    end
    cover property (read_of(`REG_SENSOR) ##1 rdata != '0);
endmodule

bind thermo_channel_setpoint_status thermo_monitor #(.REFRESH_CYCLES(REFRESH_CYCLES)) thermo_monitor_inst (
    .clock(clock), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .sensor_sw(sensor_sw), .cond_in(cond_in), .meas_temp_in(meas_temp_in),
    .ctrl_out(ctrl_out), .display_code(display_code), .status_byte(status_byte), .irq(irq));

// ### verif/host_model.sv
// register bus master standing in for the remote host
`timescale 1ns/1ps
`include "thermo_channel_consts.svh"
module host_model (
    input wire logic clock,
    output logic [`ADDR_W-1:0] addr,
    output logic [`DATA_W-1:0] wdata,
    output logic wr_en,
    output logic rd_en,
    input wire logic [`DATA_W-1:0] rdata
);
    // idle bus from time zero
    initial begin
        addr = '0;
        wdata = '0;
        wr_en = 1'h0;
        rd_en = 1'h0;
    end

    // one-cycle write; released lines show the inverse so stale data is not trusted
    // callers rely on reset selecting channel 0 and write the channel select only to change channel
    task automatic wr(input logic [`ADDR_W-1:0] a, input logic [`DATA_W-1:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr_en <= 1'h1;
        @(posedge clock);
        wr_en <= 1'h0;
        addr <= ~a;
        wdata <= ~d;
    endtask

    // one-cycle read; data taken at the end of the following cycle only
    task automatic rd(input logic [`ADDR_W-1:0] a, output logic [`DATA_W-1:0] d);
        @(posedge clock);
        addr <= a;
        rd_en <= 1'h1;
        @(posedge clock);
        rd_en <= 1'h0;
        addr <= ~a;
        @(posedge clock);
        d = rdata;
    endtask
endmodule

// ### verif/tb_top.sv
// self-checking bench for the thermo channel set point and status block
`timescale 1ns/1ps
`include "thermo_channel_consts.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
    $display("ERROR %0t: got %h, want %h", $time, (g), (e)); end end
module tb_top
    import thermo_pkg::*;
;
    localparam int REFRESH = 20;
    typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d;} row_t;
    logic clock = 1'h0;
    logic sys_rst = 1'h1;
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] wdata;
    logic wr_en;
    logic rd_en;
    logic [`DATA_W-1:0] rdata;
    sensor_sw_t sensor_sw [`NUM_CH];
    logic [`EV_W-1:0] cond_in [`NUM_CH];
    logic signed [`SP_W-1:0] meas_temp_in [`NUM_CH];
    ctrl_out_t ctrl_out [`NUM_CH];
    logic [`SENS_W-1:0] display_code [`NUM_CH];
    logic [`STB_W-1:0] status_byte;
    logic irq;
    int err_count = 0;
    int num_checks = 0;
    // reset values, set points, step limits, inc/dec, mode refusal, read-only, channel isolation
    row_t rows [40] = '{
        '{1'h0, `REG_MODE, 32'h2}, '{1'h0, `REG_STEP, 32'h1}, '{1'h0, `REG_CHAN_EN, 32'hF},
        '{1'h0, `REG_IRQ_MASK, 32'h0}, '{1'h0, `REG_SET_T, 32'h0}, '{1'h0, `REG_EVENT_EN, 32'h0},
        '{1'h1, `REG_SET_T, 32'h00FFFF38}, '{1'h0, `REG_SET_T, 32'hFFFFFF38},
        '{1'h1, `REG_SET_ITE, 32'hBB8}, '{1'h1, `REG_SET_R, 32'hD48},
        '{1'h0, `REG_SET_ITE, 32'hBB8}, '{1'h0, `REG_SET_R, 32'hD48},
        '{1'h1, `REG_STEP, 32'h270F}, '{1'h0, `REG_STEP, 32'h270F}, '{1'h1, `REG_STEP, 32'h0},
        '{1'h1, `REG_STEP, 32'h2710}, '{1'h1, `REG_STEP, 32'h10001}, '{1'h0, `REG_STEP, 32'h270F},
        '{1'h1, `REG_STEP, 32'hA}, '{1'h0, `REG_STEP, 32'hA}, '{1'h1, `REG_STEP_CMD, 32'h1},
        '{1'h0, `REG_SET_T, 32'hFFFFFF42}, '{1'h0, `REG_SET_ITE, 32'hBB8}, '{1'h1, `REG_MODE, 32'h0},
        '{1'h1, `REG_MODE, 32'h3}, '{1'h0, `REG_MODE, 32'h0}, '{1'h1, `REG_STEP_CMD, 32'h2},
        '{1'h0, `REG_SET_ITE, 32'hBAE}, '{1'h0, `REG_SET_T, 32'hFFFFFF42}, '{1'h1, `REG_SENSOR, 32'h5},
        '{1'h0, `REG_SENSOR, 32'h1}, '{1'h0, 8'hFC, 32'h0}, '{1'h1, `REG_CHAN_SEL, 32'h1},
        '{1'h0, `REG_SET_T, 32'h0}, '{1'h0, `REG_STEP, 32'h1}, '{1'h0, `REG_MODE, 32'h2},
        '{1'h1, `REG_SET_R, 32'h7}, '{1'h1, `REG_CHAN_SEL, 32'h0}, '{1'h0, `REG_SET_R, 32'hD48},
        '{1'h0, `REG_IRQ_STATUS, 32'h6}};

    always #2 clock = ~clock;

    thermo_channel_setpoint_status #(.REFRESH_CYCLES(REFRESH)) thermo_channel_setpoint_status_inst (
        .clock(clock), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
        .rdata(rdata), .sensor_sw(sensor_sw), .cond_in(cond_in), .meas_temp_in(meas_temp_in),
        .ctrl_out(ctrl_out), .display_code(display_code), .status_byte(status_byte), .irq(irq));

    host_model host_model_inst (.clock(clock), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
        .rdata(rdata));

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        host_model_inst.rd(a, d);
        `CHK(d, e)
    endtask

    task automatic end_of_test();
        if (err_count == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        tick(6000);
        err_count++;
        end_of_test();
    end

    initial begin
        logic [2:0] e;
        logic [3:0] k;
        for (int i = 0; i < `NUM_CH; i++) begin
            sensor_sw[i] = '{3'h0, 1'h1};
            cond_in[i] = '0;
            meas_temp_in[i] = '0;
        end
        tick(2);
        sys_rst <= 1'h0;
        tick(1);
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                host_model_inst.wr(rows[i].a, rows[i].d);
            end else begin
                rd_chk(rows[i].a, rows[i].d);
            end
        end
        `CHK(ctrl_out[0].target, 24'h000BAE)
        `CHK(ctrl_out[0].mode, MODE_ITE)
        // resistance mode steps its own set point and drives it
        host_model_inst.wr(`REG_MODE, 32'h1);
        host_model_inst.wr(`REG_STEP_CMD, 32'h1);
        tick(2);
        `CHK(ctrl_out[0].target, 24'h000D52)
        // every switch setting, both current positions; each step is a change
        for (int i = 0; i < 16; i++) begin
            k = i[3:0];
            e = (k[2:0] == 3'h0) ? (k[3] ? 3'h1 : 3'h2) : ((k[2:0] < 3'h4) ? k[2:0] + 3'h2 : 3'h0);
            @(posedge clock);
            sensor_sw[0] <= '{k[2:0], k[3]};
            tick(2);
            `CHK(display_code[0], e)
            rd_chk(`REG_SENSOR, 32'(e));
        end
        rd_chk(`REG_EVENT, 32'h100);
        // sensor interrupt raised when unmasked, dropped on clear
        host_model_inst.wr(`REG_IRQ_MASK, 32'h1);
        tick(1);
        `CHK(irq, 1'h1)
        host_model_inst.wr(`REG_IRQ_STATUS, 32'h1);
        tick(1);
        `CHK(irq, 1'h0)
        // summaries: event weight 1, condition weight 2, gated by channel enable
        host_model_inst.wr(`REG_EVENT_EN, 32'h100);
        rd_chk(`REG_CHAN_SUM, 32'h1);
        `CHK(status_byte, 8'h01)
        cond_in[0] <= 16'h0001;
        host_model_inst.wr(`REG_COND_EN, 32'h1);
        rd_chk(`REG_CHAN_SUM, 32'h3);
        `CHK(status_byte, 8'h03)
        host_model_inst.wr(`REG_CHAN_SEL, 32'h1);
        rd_chk(`REG_CHAN_SUM, 32'h0);
        `CHK(status_byte, 8'h03)
        host_model_inst.wr(`REG_CHAN_EN, 32'hE);
        tick(2);
        `CHK(status_byte, 8'h00)
        host_model_inst.wr(`REG_CHAN_SEL, 32'h0);
        host_model_inst.wr(`REG_EVENT, 32'h100);
        rd_chk(`REG_EVENT, 32'h0);
        // measurement refreshed while the channel is in resistance mode
        meas_temp_in[0] <= 24'h019727;
        tick(REFRESH + 5);
        rd_chk(`REG_MEAS_T, 32'h00019727);
        // second reset in mid-run restores reset values
        sys_rst <= 1'h1;
        tick(2);
        `CHK(ctrl_out[0].mode, MODE_T)
        `CHK(display_code[0], 3'h0)
        `CHK(status_byte, 8'h00)
        `CHK(irq, 1'h0)
        sys_rst <= 1'h0;
        rd_chk(`REG_SET_T, 32'h0);
        rd_chk(`REG_STEP, 32'h1);
        end_of_test();
    end
endmodule
